//--- hw/pwc_pkg.sv
// package: register map, field layout, reset values and divide table of the periodic counter
package pwc_pkg;

   // ****************************************************************
   // register map (index addresses on the plain register port)
   // ****************************************************************
   localparam logic [1:0] ADDR_STATUS_CONTROL = 2'h0;
   localparam logic [1:0] ADDR_COUNT_VALUE    = 2'h1;
   localparam logic [1:0] ADDR_MODULO_VALUE   = 2'h2;

   // ****************************************************************
   // status/control field positions
   // ****************************************************************
   localparam int FLAG_BIT   = 7;
   localparam int CKS_HI     = 6;
   localparam int CKS_LO     = 5;
   localparam int IE_BIT     = 4;
   localparam int PS_HI      = 3;
   localparam int PS_LO      = 0;

   // ****************************************************************
   // reset values and encodings
   // ****************************************************************
   localparam logic [1:0] RESET_CKS    = 2'h0;
   localparam logic [3:0] RESET_PS     = 4'h0;
   localparam logic [7:0] RESET_MODULO = 8'h00;
   localparam logic [7:0] RESET_COUNT  = 8'h00;
   localparam logic [1:0] CKS_LPO      = 2'h0;
   localparam logic [1:0] CKS_EXT      = 2'h1;
   localparam int         PRE_W        = 18;

   // divide ratio for {source bit 0, prescaler select}; zero means off
   function automatic logic [17:0] div_ratio(input logic src_bit0, input logic [3:0] sel);
      logic [17:0] r;
      r = 18'h0_0000;
      case ({src_bit0, sel})
         5'h01: r = 18'h0_0008;
         5'h02: r = 18'h0_0020;
         5'h03: r = 18'h0_0040;
         5'h04: r = 18'h0_0080;
         5'h05: r = 18'h0_0100;
         5'h06: r = 18'h0_0200;
         5'h07: r = 18'h0_0400;
         5'h08: r = 18'h0_0001;
         5'h09: r = 18'h0_0002;
         5'h0a: r = 18'h0_0004;
         5'h0b: r = 18'h0_000a;
         5'h0c: r = 18'h0_0010;
         5'h0d: r = 18'h0_0064;
         5'h0e: r = 18'h0_01f4;
         5'h0f: r = 18'h0_03e8;
         5'h11: r = 18'h0_0400;
         5'h12: r = 18'h0_0800;
         5'h13: r = 18'h0_1000;
         5'h14: r = 18'h0_2000;
         5'h15: r = 18'h0_4000;
         5'h16: r = 18'h0_8000;
         5'h17: r = 18'h1_0000;
         5'h18: r = 18'h0_03e8;
         5'h19: r = 18'h0_07d0;
         5'h1a: r = 18'h0_1388;
         5'h1b: r = 18'h0_2710;
         5'h1c: r = 18'h0_4e20;
         5'h1d: r = 18'h0_c350;
         5'h1e: r = 18'h1_86a0;
         5'h1f: r = 18'h3_0d40;
         default: r = 18'h0_0000;
      endcase
      return r;
   endfunction

endpackage

//--- hw/pwc_pre_if.sv
// interface: link between the counter core and its prescaler
interface pwc_pre_if;
   logic                        src_tick;
   logic                        clear;
   logic                        hold;
   logic [pwc_pkg::PRE_W-1:0]   ratio;
   logic                        tick;
   modport ctrl (output src_tick, output clear, output hold, output ratio, input tick);
   modport pre  (input src_tick, input clear, input hold, input ratio, output tick);
endinterface

//--- hw/pwc_prescaler.sv
// module: prescaler dividing source ticks by the selected ratio
module pwc_prescaler #(
   parameter int PRE_W = pwc_pkg::PRE_W
) (
   input  wire logic   i_sys_clk,
   input  wire logic   i_srst,
   pwc_pre_if.pre      p
);

   if (PRE_W < pwc_pkg::PRE_W) begin : g_bad_width
      $error("prescaler width too small for largest ratio");
   end

   logic [PRE_W-1:0] div_cnt;
   logic [PRE_W-1:0] ratio_w;
   logic             last;

   assign ratio_w = PRE_W'(p.ratio);
   assign last    = (div_cnt == ratio_w - PRE_W'(1));

   // ****************************************************************
   // divider; hold freezes it so counting resumes where it stopped
   // ****************************************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || p.clear || ratio_w == '0) begin
         div_cnt <= '0;
         p.tick  <= 1'b0;
      end else if (p.src_tick && !p.hold) begin
         div_cnt <= last ? '0 : div_cnt + PRE_W'(1);
         p.tick  <= last;
      end else begin
         p.tick  <= 1'b0;
      end
   end

   off_quiet_a : assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (p.ratio == '0) |=> !p.tick)
      else $error("prescaler ticked while off");

   div_one_a : assert property (@(posedge i_sys_clk) disable iff (i_srst)
      (p.ratio == 1 && p.src_tick && !p.hold && !p.clear) |=> p.tick)
      else $error("divide by one missed a source tick");

endmodule

//--- hw/pwc_top.sv
// module: periodic wake-up counter core with register port and source selection
module pwc_top (
   input  wire logic        i_sys_clk,
   input  wire logic        i_srst,
   input  wire logic [1:0]  i_addr,
   input  wire logic [7:0]  i_wr_data,
   input  wire logic        i_wr_en,
   input  wire logic        i_rd_en,
   input  wire logic        i_low_power_osc_clock,
   input  wire logic        i_external_ref_clock,
   input  wire logic        i_internal_ref_clock,
   input  wire logic        i_stop2_mode,
   input  wire logic        i_bgnd_active,
   output logic [7:0]       o_rd_data,
   output logic             o_irq
);

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (i_srst);

   // ****************************************************************
   // registers and internal nets
   // ****************************************************************
   logic [1:0]  clock_source_select;
   logic [3:0]  prescaler_select;
   logic        match_interrupt_enable;
   logic        match_flag;
   logic [7:0]  periodic_modulo_value;
   logic [7:0]  periodic_count_value;

   logic [2:0]  src_in;
   logic [2:0]  src_sync [3];
   logic [2:0]  src_level;
   logic [2:0]  src_rise;
   logic        sel_tick;

   logic        wr_status;
   logic        wr_modulo;
   logic        wr_count;
   logic [1:0]  new_cks;
   logic [3:0]  new_ps;
   logic        cfg_change;
   logic        counter_clear;
   logic        tick_ok;
   logic        at_modulo;
   logic        match_event;
   logic        next_match_flag;
   logic        next_match_interrupt_enable;

   pwc_pre_if   pre_link ();

   // ****************************************************************
   // source synchronisers: three stages, a change counts once
   // stages two and three agree
   // ****************************************************************
   assign src_in = {i_internal_ref_clock, i_external_ref_clock, i_low_power_osc_clock};

   for (genvar g = 0; g < 3; g++) begin : g_src
      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            src_sync[g] <= 3'h0;
         end else begin
            src_sync[g] <= {src_sync[g][1:0], src_in[g]};
         end
      end

      always_ff @(posedge i_sys_clk) begin
         if (i_srst) begin
            src_level[g] <= 1'b0;
         end else if (src_sync[g][1] == src_sync[g][2]) begin
            src_level[g] <= src_sync[g][2];
         end
      end

      assign src_rise[g] = src_sync[g][1] & src_sync[g][2] & ~src_level[g];
   end

   // ****************************************************************
   // source selection; in stop2 only the low-power source survives,
   // the reference clocks are gone there
   // ****************************************************************
   always_comb begin
      case (clock_source_select)
         pwc_pkg::CKS_LPO: sel_tick = src_rise[0];
         pwc_pkg::CKS_EXT: sel_tick = src_rise[1] & ~i_stop2_mode;
         default:          sel_tick = src_rise[2] & ~i_stop2_mode;
      endcase
   end

   // ****************************************************************
   // register port decode
   // ****************************************************************
   assign wr_status = i_wr_en && (i_addr == pwc_pkg::ADDR_STATUS_CONTROL);
   assign wr_modulo = i_wr_en && (i_addr == pwc_pkg::ADDR_MODULO_VALUE);
   assign wr_count  = i_wr_en && (i_addr == pwc_pkg::ADDR_COUNT_VALUE);
   assign new_cks   = i_wr_data[pwc_pkg::CKS_HI:pwc_pkg::CKS_LO];
   assign new_ps    = i_wr_data[pwc_pkg::PS_HI:pwc_pkg::PS_LO];

   // only a different value restarts the time base; rewriting the same
   // setting (e.g. to clear the flag) must not disturb the period
   assign cfg_change = wr_status &&
                       ((new_cks != clock_source_select) || (new_ps != prescaler_select));
   assign counter_clear = cfg_change || wr_modulo;

   // ****************************************************************
   // prescaler
   // ****************************************************************
   assign pre_link.src_tick = sel_tick;
   assign pre_link.clear    = counter_clear;
   assign pre_link.hold     = i_bgnd_active;
   assign pre_link.ratio    = pwc_pkg::div_ratio(clock_source_select[0],
                                                 prescaler_select);

   pwc_prescaler #(
      .PRE_W (pwc_pkg::PRE_W)
   ) u_prescaler (
      .i_sys_clk (i_sys_clk),
      .i_srst    (i_srst),
      .p         (pre_link.pre)
   );

   // ****************************************************************
   // control fields
   // ****************************************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         clock_source_select <= pwc_pkg::RESET_CKS;
         prescaler_select    <= pwc_pkg::RESET_PS;
      end else if (wr_status) begin
         clock_source_select <= new_cks;
         prescaler_select    <= new_ps;
      end
   end

   assign next_match_interrupt_enable = wr_status ? i_wr_data[pwc_pkg::IE_BIT]
                                                  : match_interrupt_enable;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         match_interrupt_enable <= 1'b0;
      end else begin
         match_interrupt_enable <= next_match_interrupt_enable;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         periodic_modulo_value <= pwc_pkg::RESET_MODULO;
      end else if (wr_modulo) begin
         periodic_modulo_value <= i_wr_data;
      end
   end

   // ****************************************************************
   // main counter; no wait or stop input here on purpose: the core
   // keeps counting whenever its source ticks, except in background mode
   // ****************************************************************
   assign tick_ok     = pre_link.tick && !i_bgnd_active;
   assign at_modulo   = (periodic_count_value == periodic_modulo_value);
   assign match_event = tick_ok && at_modulo && !counter_clear;

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         periodic_count_value <= pwc_pkg::RESET_COUNT;
      end else if (counter_clear) begin
         periodic_count_value <= pwc_pkg::RESET_COUNT;
      end else if (tick_ok) begin
         periodic_count_value <= at_modulo ? pwc_pkg::RESET_COUNT
                                           : periodic_count_value + 8'h01;
      end
   end

   // ****************************************************************
   // match flag and request; a match in the clearing cycle wins
   // ****************************************************************
   assign next_match_flag = match_event ||
                            (match_flag && !(wr_status && i_wr_data[pwc_pkg::FLAG_BIT]));

   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         match_flag <= 1'b0;
      end else begin
         match_flag <= next_match_flag;
      end
   end

   // registered from the next values so the request tracks the flag
   always_ff @(posedge i_sys_clk) begin
      if (i_srst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= next_match_flag && next_match_interrupt_enable;
      end
   end

   // ****************************************************************
   // read port; data valid only in the cycle after the strobe
   // ****************************************************************
   always_ff @(posedge i_sys_clk) begin
      if (i_srst || !i_rd_en) begin
         o_rd_data <= 8'h00;
      end else begin
         case (i_addr)
            pwc_pkg::ADDR_STATUS_CONTROL: o_rd_data <= {match_flag, clock_source_select,
                                                        match_interrupt_enable,
                                                        prescaler_select};
            pwc_pkg::ADDR_COUNT_VALUE:    o_rd_data <= periodic_count_value;
            pwc_pkg::ADDR_MODULO_VALUE:   o_rd_data <= periodic_modulo_value;
            default:                      o_rd_data <= 8'h00;
         endcase
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   sequence s_wrap_tick;
      tick_ok && at_modulo && !counter_clear;
   endsequence

   sequence s_wrapped;
      (periodic_count_value == 8'h00) && match_flag;
   endsequence

   sequence s_cfg_write;
      cfg_change;
   endsequence

   count_wrap_a : assert property (s_wrap_tick |=> s_wrapped)
      else $error("counter did not wrap with flag at modulo");

   count_step_a : assert property (
      (tick_ok && !at_modulo && !counter_clear) |=>
      periodic_count_value == $past(periodic_count_value) + 8'h01)
      else $error("counter did not step by one");

   flag_cause_a : assert property (
      (!match_flag ##1 match_flag) |-> $past(match_event))
      else $error("flag set without a match");

   flag_clear_a : assert property (
      (wr_status && i_wr_data[pwc_pkg::FLAG_BIT] && !match_event) |=> !match_flag && !o_irq)
      else $error("write one did not clear flag and request");

   flag_keep_a : assert property (
      (match_flag && wr_status && !i_wr_data[pwc_pkg::FLAG_BIT]) |=> match_flag)
      else $error("write zero disturbed flag");

   irq_gate_a : assert property (
      ##1 (o_irq == (match_flag && match_interrupt_enable)))
      else $error("request does not follow flag and enable");

   cfg_clear_a : assert property (s_cfg_write |=> ##[0:1]
      (periodic_count_value == 8'h00 && !pre_link.tick))
      else $error("config change did not clear the time base");

   mod_clear_a : assert property (
      wr_modulo |=> periodic_count_value == 8'h00 && !pre_link.tick)
      else $error("modulo write did not clear the counter");

   bgnd_hold_a : assert property (
      (i_bgnd_active && !counter_clear) |=> $stable(periodic_count_value))
      else $error("counter moved in background mode");

   count_ro_a : assert property (
      (wr_count && !tick_ok) |=> $stable(periodic_count_value))
      else $error("count register write took effect");

   count_read_a : assert property (
      (i_rd_en && i_addr == pwc_pkg::ADDR_COUNT_VALUE) |=>
      o_rd_data == $past(periodic_count_value))
      else $error("count read returned wrong value");

   stop2_gate_a : assert property (
      (i_stop2_mode && clock_source_select != pwc_pkg::CKS_LPO) |-> !sel_tick)
      else $error("reference source ticked in stop2");

   // ****************************************************************
   // checks on reset values, field writes, modulo zero, background exit and the read port
   // ****************************************************************
   // reset must win even while the disable is active, so this one
   // carries its own clock and no disable
   reset_values_a : assert property (@(posedge i_sys_clk) disable iff (1'b0)
      $past(i_srst) |-> (periodic_count_value == 8'h00 && periodic_modulo_value == 8'h00 &&
                         prescaler_select == 4'h0 &&
                         clock_source_select == pwc_pkg::CKS_LPO && !match_flag))
      else $error("reset left a register set");

   field_write_a : assert property (
      wr_status |=> (clock_source_select == $past(new_cks) &&
                     prescaler_select == $past(new_ps)))
      else $error("status write did not load the fields");

   ie_write_a : assert property (
      wr_status |=> match_interrupt_enable == $past(i_wr_data[pwc_pkg::IE_BIT]))
      else $error("status write did not load the enable");

   mod_zero_a : assert property (
      (tick_ok && periodic_modulo_value == 8'h00 && !counter_clear) |=> match_flag)
      else $error("modulo zero tick did not set the flag");

   // resume needs the held value on the first cycle out of background
   sequence s_bgnd_exit;
      $fell(i_bgnd_active) && !$past(counter_clear);
   endsequence

   bgnd_resume_a : assert property (
      s_bgnd_exit |-> $stable(periodic_count_value))
      else $error("count lost on leaving background mode");

   status_read_a : assert property (
      (i_rd_en && i_addr == pwc_pkg::ADDR_STATUS_CONTROL) |=>
      o_rd_data == {$past(match_flag), $past(clock_source_select),
                    $past(match_interrupt_enable), $past(prescaler_select)})
      else $error("status read returned wrong value");

   rd_idle_a : assert property (
      !i_rd_en |=> o_rd_data == 8'h00)
      else $error("read data stood without a strobe");

endmodule

//--- testbench/test_periodic_wakeup_counter.sv
// testbench: register-level scenarios for the periodic wake-up counter
module test_periodic_wakeup_counter;
   timeunit 1ns;
   timeprecision 1ps;

   // ****************************************************************
   // stimulus and observed signals
   // ****************************************************************
   logic       i_sys_clk;
   logic       i_srst;
   logic [1:0] i_addr;
   logic [7:0] i_wr_data;
   logic       i_wr_en;
   logic       i_rd_en;
   logic [2:0] src;
   logic       i_stop2_mode;
   logic       i_bgnd_active;
   logic [7:0] o_rd_data;
   logic       o_irq;
   int         n_errors;
   int         checks;
   int         cycles;
   logic [3:0] sel_tab [6];
   int         div_tab [6];

   pwc_top uut (
      .i_sys_clk             (i_sys_clk),
      .i_srst                (i_srst),
      .i_addr                (i_addr),
      .i_wr_data             (i_wr_data),
      .i_wr_en               (i_wr_en),
      .i_rd_en               (i_rd_en),
      .i_low_power_osc_clock (src[0]),
      .i_external_ref_clock  (src[1]),
      .i_internal_ref_clock  (src[2]),
      .i_stop2_mode          (i_stop2_mode),
      .i_bgnd_active         (i_bgnd_active),
      .o_rd_data             (o_rd_data),
      .o_irq                 (o_irq)
   );

   initial i_sys_clk = 1'b0;
   always #25 i_sys_clk = ~i_sys_clk;

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr_en   <= 1'b1;
      @(posedge i_sys_clk);
      i_wr_en   <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_check(input logic [1:0] a, input logic [7:0] exp, input string what);
      @(posedge i_sys_clk);
      i_addr  <= a;
      i_rd_en <= 1'b1;
      @(posedge i_sys_clk);
      i_rd_en <= 1'b0;
      #1;
      check(what, o_rd_data, exp);
   endtask

   // slow source edges: 6 cycles high, 7 low between pulses, well under sys_clk/6
   task automatic pulse(input int which, input int n);
      repeat (n) begin
         @(posedge i_sys_clk);
         src[which] <= 1'b1;
         repeat (6) @(posedge i_sys_clk);
         src[which] <= 1'b0;
         repeat (6) @(posedge i_sys_clk);
      end
   endtask

   task automatic irq_check(input logic exp);
      repeat (3) @(posedge i_sys_clk);
      #1;
      check("irq", {7'h00, o_irq}, {7'h00, exp});
   endtask

   // hang guard: the full run needs about 16000 cycles
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_errors++;
         $display("[FAIL] timeout expected done seen running");
         tally_and_finish();
      end
   end

   // ****************************************************************
   // scenarios
   // ****************************************************************
   initial begin
      n_errors      = 0;
      checks        = 0;
      cycles        = 0;
      i_srst        = 1'b1;
      i_addr        = 2'h0;
      i_wr_data     = 8'h00;
      i_wr_en       = 1'b0;
      i_rd_en       = 1'b0;
      src           = 3'h0;
      i_stop2_mode  = 1'b0;
      i_bgnd_active = 1'b0;
      sel_tab = '{4'h8, 4'ha, 4'hb, 4'h1, 4'hc, 4'hd};
      div_tab = '{1, 4, 10, 8, 16, 100};
      repeat (6) @(posedge i_sys_clk);
      i_srst <= 1'b0;
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h00, "status");
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      rd_check(pwc_pkg::ADDR_MODULO_VALUE, 8'h00, "modulo");
      rd_check(2'h3, 8'h00, "unmapped");
      wr(pwc_pkg::ADDR_MODULO_VALUE, 8'h03);
      rd_check(pwc_pkg::ADDR_MODULO_VALUE, 8'h03, "modulo");
      wr(pwc_pkg::ADDR_COUNT_VALUE, 8'h55);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      // divide by 1 from the low-power source, wrap at modulo 3
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h08);
      pulse(0, 3);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h03, "count");
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h08, "status");
      pulse(0, 1);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h88, "status");
      irq_check(1'b0);
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h18);
      irq_check(1'b1);
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h98, "status");
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h98);
      irq_check(1'b0);
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h18, "status");
      // a new divide select clears the count
      pulse(0, 2);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h02, "count");
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h09);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      // one tick after exactly the divide ratio of source edges
      wr(pwc_pkg::ADDR_MODULO_VALUE, 8'hff);
      foreach (sel_tab[i]) begin
         wr(pwc_pkg::ADDR_STATUS_CONTROL, {4'h0, sel_tab[i]});
         pulse(0, div_tab[i] - 1);
         rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
         pulse(0, 1);
         rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h01, "count");
      end
      // software stops the counter when no wake-up is wanted
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h00);
      pulse(0, 3);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      // external source with the long table: select 1 divides by 1024;
      // the bench source toggles only once selected, as software must ensure
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h21);
      pulse(1, 1023);
      pulse(0, 4);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      pulse(1, 1);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h01, "count");
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h48);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      pulse(2, 2);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h02, "count");
      // stop2 keeps only the low-power source alive
      @(posedge i_sys_clk);
      i_stop2_mode <= 1'b1;
      pulse(2, 3);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h02, "count");
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h08);
      pulse(0, 2);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h02, "count");
      @(posedge i_sys_clk);
      i_stop2_mode <= 1'b0;
      // background mode freezes, then counting resumes from the held value
      @(posedge i_sys_clk);
      i_bgnd_active <= 1'b1;
      pulse(0, 3);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h02, "count");
      @(posedge i_sys_clk);
      i_bgnd_active <= 1'b0;
      pulse(0, 1);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h03, "count");
      // modulo write clears; modulo zero flags every tick
      wr(pwc_pkg::ADDR_MODULO_VALUE, 8'h00);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h08, "status");
      pulse(0, 1);
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h88, "status");
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h88);
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h08, "status");
      pulse(0, 1);
      rd_check(pwc_pkg::ADDR_STATUS_CONTROL, 8'h88, "status");
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h00, "count");
      // same-value status write must not disturb the count
      wr(pwc_pkg::ADDR_MODULO_VALUE, 8'hff);
      pulse(0, 2);
      wr(pwc_pkg::ADDR_STATUS_CONTROL, 8'h08);
      rd_check(pwc_pkg::ADDR_COUNT_VALUE, 8'h02, "count");
      tally_and_finish();
   end
endmodule
